// ### rtl/eeprom_config_autoload.sv
/*
  serial EEPROM configuration loader: reads the 13-word image after reset,
  decodes pm, id and station address fields, drives PME#/wake pins.
  assumes an Avalon-MM master on clock_i and pins synchronised here.
*/
// Overview of operation
// - pm byte bits 7..3 land in pm register bits 31..27.
// - pm byte bits 2..0 land in pm register bits 21, 26 and 25 in that order.
// - with control bit 14 set the PHY is not powered down while the phy_pin_a pin is low.
// - with control bit 13 set the power-state field is cleared while PCI reset is low.
// - with control bit 12 set PME# is driven as a level, not a pulse.
// - with control bit 11 set the wake output pin is not driven.
// - with control bit 10 set PME# is not driven.
// - with control bit 9 set a link change is a wake event.
// - with control bit 8 set a magic packet is a wake event.
// - station address bytes 0..5 are words 10..12, low byte before high byte.
// - vendor and device ids load only when the control low nibble is 1010, else defaults.
// - capability enable, pm byte and control byte load only when the high nibble is 1X1X.
// - after reset the first 13 words of the EEPROM are read.
`timescale 1ns/100ps
module eeprom_config_autoload #(
  parameter logic [15:0] DEF_VENDOR_ID = 16'h1234,  // arbitrary value
  parameter logic [15:0] DEF_DEVICE_ID = 16'h5678,  // arbitrary value
  parameter logic [7:0] PME_PULSE_CYCLES = 8'h10
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // avalon-mm slave
  input wire cfg_load_pkg::avmm_req_t avs_req_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // serial eeprom
  output cfg_load_pkg::ee_pins_t ee_o,
  input wire logic ee_do_i,
  // pins
  input wire logic phy_pin_a_i,
  input wire logic pci_rst_n_i,
  input wire logic pme_n_i,
  output logic pme_n_o,
  output logic pme_n_oe_o,
  output logic wake_output_pin_o,
  output logic wake_output_pin_oe_o,
  // power-management logic
  input wire logic phy_pd_req_i,
  input wire logic link_change_i,
  input wire logic magic_pkt_i,
  output logic phy_pd_o,
  output logic wake_o,
  // loaded configuration
  output logic [31:0] pci_power_mgmt_reg_o,
  output logic [1:0] pm_control_status_o,
  output logic new_capabilities_enable_o,
  output logic [15:0] vendor_id_o,
  output logic [15:0] device_id_o,
  output logic [15:0] subsys_vendor_id_o,
  output logic [15:0] subsys_id_o,
  output logic [47:0] station_addr_o,
  output logic load_done_o
);
  import cfg_load_pkg::*;

  typedef struct packed {
    logic [1:0] eedo_sync;
    logic [1:0] pin_a_sync;
    logic [1:0] rst_sync;
    logic [1:0] pme_sync;
    ld_state_t st;
    logic [TICK_W-1:0] tick_cnt;
    logic phase;
    logic [4:0] bit_cnt;
    logic [3:0] word_idx;
    logic [15:0] shreg;
    logic [N_WORDS-1:0][15:0] shadow;
    ee_pins_t ee;
    logic done;
    logic [7:0] alc;
    logic [7:0] new_capabilities_enable;
    logic [7:0] pm_capabilities;
    logic [7:0] ctl;
    logic [15:0] vendor;
    logic [15:0] device;
    logic [15:0] ss_vendor;
    logic [15:0] ss_id;
    logic [47:0] mac;
    logic [1:0] pstate;
    logic pme_status;
    logic [7:0] pulse_cnt;
    logic ack;
    logic [31:0] rdata;
  } state_t;

  localparam state_t RESET_STATE = '{
    eedo_sync: 2'h0, pin_a_sync: 2'h3, rst_sync: 2'h0, pme_sync: 2'h3,
    st: ST_IDLE, tick_cnt: '0, phase: 1'b0, bit_cnt: 5'h00, word_idx: 4'h0,
    shreg: 16'h0000, shadow: '0, ee: '0, done: 1'b0,
    alc: 8'h00, new_capabilities_enable: 8'h00, pm_capabilities: 8'h00, ctl: 8'h00,
    vendor: DEF_VENDOR_ID, device: DEF_DEVICE_ID, ss_vendor: 16'h0000,
    ss_id: 16'h0000, mac: 48'h0, pstate: 2'h0, pme_status: 1'b0,
    pulse_cnt: 8'h00, ack: 1'b0, rdata: 32'h0000_0000
  };

  state_t s_ff;
  state_t nxt_s;

  // command bit sent at position idx of the read frame for word w
  function automatic logic cmd_bit(input logic [3:0] w, input logic [4:0] idx);
    logic [8:0] cmd;
    cmd = {EE_READ_OP, 2'h0, w};
    return cmd[4'(CMD_LAST_BIT - idx)];
  endfunction

  // pm register image from the pm byte
  function automatic logic [31:0] build_pmr(input logic [7:0] pm_capabilities);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[31:27] = pm_capabilities[7:3];
    r[21] = pm_capabilities[2];
    r[26:25] = pm_capabilities[1:0];
    return r;
  endfunction

  logic tick;
  logic req;
  logic wr_take;
  logic wake;
  logic pme_active;
  logic [15:0] w_alc;
  logic [15:0] w_pm;
  logic ids_en;
  logic pm_en;

  assign tick = (s_ff.tick_cnt == TICK_LAST);
  assign req = avs_req_i.read | avs_req_i.write;
  assign wr_take = avs_req_i.write & s_ff.ack;
  assign w_alc = s_ff.shadow[W_AUTOLOAD];
  assign w_pm = s_ff.shadow[W_PM];
  assign ids_en = (w_alc[3:0] == ID_LOAD_KEY);
  assign pm_en = w_alc[ALC_PM_EN_A] & w_alc[ALC_PM_EN_B];
  assign wake = (s_ff.ctl[CTL_LINK_WAKE] & link_change_i)
    | (s_ff.ctl[CTL_MAGIC_WAKE] & magic_pkt_i);
  assign pme_active = s_ff.ctl[CTL_PME_LEVEL] ? s_ff.pme_status
    : (s_ff.pulse_cnt != 8'h00);

  always_comb begin
    nxt_s = s_ff;
    nxt_s.eedo_sync = {s_ff.eedo_sync[0], ee_do_i};
    nxt_s.pin_a_sync = {s_ff.pin_a_sync[0], phy_pin_a_i};
    nxt_s.rst_sync = {s_ff.rst_sync[0], pci_rst_n_i};
    nxt_s.pme_sync = {s_ff.pme_sync[0], pme_n_i};
    nxt_s.tick_cnt = tick ? '0 : TICK_W'(s_ff.tick_cnt + 1'b1);

    // image read: one framed read per word, 13 words
    unique case (s_ff.st)
      ST_IDLE: begin
        nxt_s.word_idx = 4'h0;
        nxt_s.bit_cnt = 5'h00;
        nxt_s.phase = 1'b0;
        nxt_s.tick_cnt = '0;
        nxt_s.ee.cs = 1'b1;
        nxt_s.ee.sk = 1'b0;
        nxt_s.ee.di = cmd_bit(4'h0, 5'h00);
        nxt_s.st = ST_CMD;
      end
      ST_CMD, ST_DATA: begin
        if (tick) begin
          nxt_s.phase = ~s_ff.phase;
          nxt_s.ee.sk = ~s_ff.phase;
          if (s_ff.phase) begin
            nxt_s.bit_cnt = 5'(s_ff.bit_cnt + 1'b1);
            if (s_ff.st == ST_CMD) begin
              if (s_ff.bit_cnt == CMD_LAST_BIT) begin
                nxt_s.st = ST_DATA;
                nxt_s.bit_cnt = 5'h00;
                nxt_s.ee.di = 1'b0;
              end else begin
                nxt_s.ee.di = cmd_bit(s_ff.word_idx, 5'(s_ff.bit_cnt + 1'b1));
              end
            end else begin
              nxt_s.shreg = {s_ff.shreg[14:0], s_ff.eedo_sync[1]};
              if (s_ff.bit_cnt == DATA_LAST_BIT) begin
                nxt_s.shadow[s_ff.word_idx] = {s_ff.shreg[14:0], s_ff.eedo_sync[1]};
                nxt_s.ee.cs = 1'b0;
                nxt_s.st = ST_GAP;
              end
            end
          end
        end
      end
      ST_GAP: begin
        if (tick) begin
          if (s_ff.word_idx == W_LAST) begin
            nxt_s.st = ST_DONE;
            nxt_s.done = 1'b1;
            nxt_s.alc = w_alc[7:0];
            nxt_s.ss_vendor = s_ff.shadow[W_SUBSYS_VID];
            nxt_s.ss_id = s_ff.shadow[W_SUBSYS_ID];
            nxt_s.vendor = ids_en ? s_ff.shadow[W_VENDOR] : DEF_VENDOR_ID;
            nxt_s.device = ids_en ? s_ff.shadow[W_DEVICE] : DEF_DEVICE_ID;
            nxt_s.new_capabilities_enable = pm_en ? w_alc[15:8] : 8'h00;
            nxt_s.pm_capabilities = pm_en ? w_pm[7:0] : 8'h00;
            nxt_s.ctl = pm_en ? w_pm[15:8] : 8'h00;
            nxt_s.mac = {s_ff.shadow[W_MAC2], s_ff.shadow[W_MAC1],
                         s_ff.shadow[W_MAC0]};
          end else begin
            nxt_s.word_idx = 4'(s_ff.word_idx + 1'b1);
            nxt_s.bit_cnt = 5'h00;
            nxt_s.ee.cs = 1'b1;
            nxt_s.ee.di = cmd_bit(4'(s_ff.word_idx + 1'b1), 5'h00);
            nxt_s.st = ST_CMD;
          end
        end
      end
      ST_DONE: begin
      end
    endcase

    // bus: one wait cycle, answer on the second edge
    nxt_s.ack = req & ~s_ff.ack;
    if (req && !s_ff.ack) begin
      unique case (avs_req_i.address)
        REG_STATUS: nxt_s.rdata = {27'h0, s_ff.pme_status, s_ff.pme_sync[1],
                                  pm_en & s_ff.done, ids_en & s_ff.done, s_ff.done};
        REG_PM_CONTROL_STATUS: nxt_s.rdata = {16'h0, s_ff.pme_status, 13'h0, s_ff.pstate};
        REG_PMR: nxt_s.rdata = build_pmr(s_ff.pm_capabilities);
        REG_IDS: nxt_s.rdata = {s_ff.device, s_ff.vendor};
        REG_SUBSYS: nxt_s.rdata = {s_ff.ss_id, s_ff.ss_vendor};
        REG_MAC_LO: nxt_s.rdata = s_ff.mac[31:0];
        REG_MAC_HI: nxt_s.rdata = {s_ff.alc, s_ff.ctl, s_ff.mac[47:32]};
        default: nxt_s.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_take && avs_req_i.address == REG_CTRL
        && avs_req_i.writedata[CTRL_RELOAD] && s_ff.st == ST_DONE) begin
      nxt_s.st = ST_IDLE;
    end
    if (wr_take && avs_req_i.address == REG_PM_CONTROL_STATUS) begin
      nxt_s.pstate = avs_req_i.writedata[1:0];
      if (avs_req_i.writedata[PM_CONTROL_STATUS_PME_STS]) begin
        nxt_s.pme_status = 1'b0;
      end
    end
    if (s_ff.ctl[CTL_CLR_PSTATE] && !s_ff.rst_sync[1]) begin
      nxt_s.pstate = 2'h0;
    end

    // wake events: set wins over software clear
    if (wake) begin
      nxt_s.pme_status = 1'b1;
      nxt_s.pulse_cnt = PME_PULSE_CYCLES;
    end else if (s_ff.pulse_cnt != 8'h00) begin
      nxt_s.pulse_cnt = 8'(s_ff.pulse_cnt - 1'b1);
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_ff <= RESET_STATE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign avs_waitrequest_o = req & ~s_ff.ack;
  assign avs_readdata_o = s_ff.rdata;
  assign ee_o = s_ff.ee;
  assign pme_n_o = 1'b0;
  assign pme_n_oe_o = pme_active & ~s_ff.ctl[CTL_PME_OFF];
  assign wake_output_pin_o = (s_ff.alc[ALC_WOL_LEVEL] ? s_ff.pme_status
    : (s_ff.pulse_cnt != 8'h00)) ^ s_ff.alc[ALC_WOL_LOW];
  assign wake_output_pin_oe_o = s_ff.done & ~s_ff.ctl[CTL_WOL_OFF];
  assign phy_pd_o = phy_pd_req_i
    & ~(s_ff.ctl[CTL_KEEP_PHY] & ~s_ff.pin_a_sync[1]);
  assign wake_o = pme_active;
  assign pci_power_mgmt_reg_o = build_pmr(s_ff.pm_capabilities);
  assign pm_control_status_o = s_ff.pstate;
  assign new_capabilities_enable_o = s_ff.new_capabilities_enable[0];
  assign vendor_id_o = s_ff.vendor;
  assign device_id_o = s_ff.device;
  assign subsys_vendor_id_o = s_ff.ss_vendor;
  assign subsys_id_o = s_ff.ss_id;
  assign station_addr_o = s_ff.mac;
  assign load_done_o = s_ff.done;
endmodule

// ### rtl/cfg_load_pkg.sv
/*
  constants, types and carriers for the configuration image loader.
  assumes a 200 MHz core clock and a 3-wire serial EEPROM in 16-bit word mode.
*/
package cfg_load_pkg;
  // core clock and serial clock timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int EECK_PERIOD_NS = 2560;
  localparam int EECK_HALF_CYC = EECK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int TICK_W = 9;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(EECK_HALF_CYC - 1);

  // image layout, word indices
  localparam int N_WORDS = 13;
  localparam logic [3:0] W_SUBSYS_VID = 4'h0;
  localparam logic [3:0] W_SUBSYS_ID = 4'h1;
  localparam logic [3:0] W_AUTOLOAD = 4'h4;
  localparam logic [3:0] W_VENDOR = 4'h5;
  localparam logic [3:0] W_DEVICE = 4'h6;
  localparam logic [3:0] W_PM = 4'h7;
  localparam logic [3:0] W_MAC0 = 4'hA;
  localparam logic [3:0] W_MAC1 = 4'hB;
  localparam logic [3:0] W_MAC2 = 4'hC;
  localparam logic [3:0] W_LAST = 4'hC;

  // serial read command: start bit and read opcode
  localparam logic [2:0] EE_READ_OP = 3'h6;
  localparam logic [4:0] CMD_LAST_BIT = 5'h08;
  localparam logic [4:0] DATA_LAST_BIT = 5'h0F;

  // auto-load control byte
  localparam logic [3:0] ID_LOAD_KEY = 4'hA;
  localparam int ALC_PM_EN_A = 7;
  localparam int ALC_PM_EN_B = 5;
  localparam int ALC_WOL_LEVEL = 6;
  localparam int ALC_WOL_LOW = 4;

  // control byte (high byte of pm word), positions within the byte
  localparam int CTL_KEEP_PHY = 6;
  localparam int CTL_CLR_PSTATE = 5;
  localparam int CTL_PME_LEVEL = 4;
  localparam int CTL_WOL_OFF = 3;
  localparam int CTL_PME_OFF = 2;
  localparam int CTL_LINK_WAKE = 1;
  localparam int CTL_MAGIC_WAKE = 0;

  // register map, byte addresses
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] REG_STATUS = 6'h00;
  localparam logic [ADDR_W-1:0] REG_CTRL = 6'h04;
  localparam logic [ADDR_W-1:0] REG_PM_CONTROL_STATUS = 6'h08;
  localparam logic [ADDR_W-1:0] REG_PMR = 6'h0C;
  localparam logic [ADDR_W-1:0] REG_IDS = 6'h10;
  localparam logic [ADDR_W-1:0] REG_SUBSYS = 6'h14;
  localparam logic [ADDR_W-1:0] REG_MAC_LO = 6'h18;
  localparam logic [ADDR_W-1:0] REG_MAC_HI = 6'h1C;
  localparam int CTRL_RELOAD = 0;
  localparam int PM_CONTROL_STATUS_PME_STS = 15;

  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_DATA, ST_GAP, ST_DONE} ld_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } avmm_req_t;

  typedef struct packed {
    logic cs;
    logic sk;
    logic di;
  } ee_pins_t;
endpackage

// ### sim/eeprom_config_autoload_props.sv
/*
  port checker for the configuration loader.
  assumes it is bound onto the loader; one clock domain.
*/
`timescale 1ns/100ps
module eeprom_config_autoload_props
  import cfg_load_pkg::*;
#(
  parameter logic [15:0] DEF_VENDOR_ID = 16'h0000,
  parameter logic [15:0] DEF_DEVICE_ID = 16'h0000
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // watched ports
  input wire cfg_load_pkg::avmm_req_t avs_req_i,
  input wire logic avs_waitrequest_o,
  input wire cfg_load_pkg::ee_pins_t ee_o,
  input wire logic phy_pd_req_i,
  input wire logic phy_pd_o,
  input wire logic pme_n_o,
  input wire logic wake_output_pin_oe_o,
  input wire logic wake_o,
  input wire logic [31:0] pci_power_mgmt_reg_o,
  input wire logic [15:0] vendor_id_o,
  input wire logic [15:0] device_id_o,
  input wire logic [47:0] station_addr_o,
  input wire logic load_done_o
);
  logic sk_ff;
  logic [TICK_W-1:0] hi_cnt_ff;
  // cycles since the serial clock last changed
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sk_ff <= 1'b0;
      hi_cnt_ff <= '0;
    end else begin
      sk_ff <= ee_o.sk;
      hi_cnt_ff <= (ee_o.sk != sk_ff) ? '0 : hi_cnt_ff + 1'b1;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  a_wait_one_cycle: assert property (
    (avs_req_i.read || avs_req_i.write) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest held too long");
  a_cmd_start_bit: assert property ($rose(ee_o.cs) |-> ee_o.di)
    else $error("word read without start bit");
  a_sk_high_half: assert property ($fell(ee_o.sk) |-> hi_cnt_ff == TICK_LAST)
    else $error("serial clock high phase wrong");
  a_ids_default: assert property (
    !load_done_o |-> vendor_id_o == DEF_VENDOR_ID && device_id_o == DEF_DEVICE_ID)
    else $error("ids not default before load");
  a_fields_frozen: assert property (
    !load_done_o ##1 !load_done_o |-> $stable(station_addr_o) && $stable(pci_power_mgmt_reg_o))
    else $error("fields moved during load");
  a_pm_rest_zero: assert property (
    pci_power_mgmt_reg_o[24:22] == 3'h0 && pci_power_mgmt_reg_o[20:0] == 21'h0)
    else $error("pm register stray bits");
  a_phy_gate: assert property (phy_pd_o |-> phy_pd_req_i)
    else $error("phy powered down unasked");
  a_pme_drain: assert property (pme_n_o == 1'b0)
    else $error("wake line driven high");
  a_wake_oe_done: assert property (wake_output_pin_oe_o |-> load_done_o)
    else $error("wake pin driven before load");
  c_load: cover property ($rose(load_done_o));
  c_wake: cover property ($rose(wake_o));
  c_read: cover property (avs_req_i.read && !avs_waitrequest_o);
endmodule

bind eeprom_config_autoload eeprom_config_autoload_props #(
  .DEF_VENDOR_ID(DEF_VENDOR_ID), .DEF_DEVICE_ID(DEF_DEVICE_ID)
) props_i (
  .clock_i(clock_i), .arst_n_i(arst_n_i), .avs_req_i(avs_req_i),
  .avs_waitrequest_o(avs_waitrequest_o), .ee_o(ee_o), .phy_pd_req_i(phy_pd_req_i),
  .phy_pd_o(phy_pd_o), .pme_n_o(pme_n_o), .wake_output_pin_oe_o(wake_output_pin_oe_o),
  .wake_o(wake_o), .pci_power_mgmt_reg_o(pci_power_mgmt_reg_o), .vendor_id_o(vendor_id_o),
  .device_id_o(device_id_o), .station_addr_o(station_addr_o), .load_done_o(load_done_o)
);

// ### sim/eeprom_model.sv
/*
  behavioural serial EEPROM, 64 words of 16 bits.
  assumes di moves at sk fall and do is sampled at sk fall.
*/
`timescale 1ns/100ps
module eeprom_model (
  // serial pins
  input wire cfg_load_pkg::ee_pins_t ee_i,
  output logic do_o
);
  logic [15:0] mem [64];
  logic [8:0] cmd;
  logic bad;
  int bits;
  int words;
  initial begin
    do_o = 1'b0;
    bad = 1'b0;
    bits = 0;
    words = 0;
  end
  always @(posedge ee_i.cs) begin
    bits = 0;
  end
  // released line shows the inverse of its last value
  always @(negedge ee_i.cs) begin
    do_o = ~do_o;
  end
  always @(posedge ee_i.sk) begin
    if (ee_i.cs) begin
      bits = bits + 1;
      if (bits <= 9) cmd = {cmd[7:0], ee_i.di};
      if (bits == 9 && cmd[8:6] != 3'h6) bad = 1'b1;
      if (bits >= 10 && bits <= 25) do_o = mem[cmd[5:0]][25 - bits];
      if (bits == 25) words = words + 1;
    end
  end
endmodule

// ### sim/testbench.sv
/*
  self-checking bench for the configuration loader.
  assumes the behavioural EEPROM model and the package constants.
*/
`timescale 1ns/100ps
module testbench;
  import cfg_load_pkg::*;
  localparam logic [15:0] DEF_VID = 16'h0BAD;  // arbitrary value
  localparam logic [15:0] DEF_DID = 16'h0CAB;  // arbitrary value
  localparam logic [7:0] ALC = 8'hBA;
  localparam logic [7:0] PMB = 8'hB5;
  localparam logic [7:0] CTL = 8'h62;
  logic clock_i, arst_n_i, wait_o, ee_do, pin_a, pci_rst_n, pme_n, pme_oe, wake_output_pin, wol_oe;
  logic pd_req, link, magic, pd, wake, new_capabilities_enable, done;
  logic [31:0] rdata, rd, pmr;
  logic [1:0] pstate;
  logic [15:0] vid, did, svid, sid;
  logic [47:0] mac;
  avmm_req_t req;
  ee_pins_t ee;
  wire pme_wire = pme_oe ? pme_n : 1'b1;
  int error_cnt;
  int checked;
  eeprom_model eeprom_model_i (.ee_i(ee), .do_o(ee_do));
  eeprom_config_autoload #(.DEF_VENDOR_ID(DEF_VID), .DEF_DEVICE_ID(DEF_DID))
    eeprom_config_autoload_i (.clock_i(clock_i), .arst_n_i(arst_n_i), .avs_req_i(req),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o), .ee_o(ee), .ee_do_i(ee_do),
    .phy_pin_a_i(pin_a), .pci_rst_n_i(pci_rst_n), .pme_n_i(pme_wire), .pme_n_o(pme_n),
    .pme_n_oe_o(pme_oe), .wake_output_pin_o(wake_output_pin), .wake_output_pin_oe_o(wol_oe),
    .phy_pd_req_i(pd_req), .link_change_i(link), .magic_pkt_i(magic), .phy_pd_o(pd),
    .wake_o(wake), .pci_power_mgmt_reg_o(pmr), .pm_control_status_o(pstate),
    .new_capabilities_enable_o(new_capabilities_enable), .vendor_id_o(vid), .device_id_o(did),
    .subsys_vendor_id_o(svid), .subsys_id_o(sid), .station_addr_o(mac), .load_done_o(done));
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    req <= '{address: a, read: !wr, write: wr, writedata: d};
    do begin
      @(posedge clock_i);
      n++;
    end while (wait_o !== 1'b0 && n < 100);
    if (n >= 100) error_cnt++;
    rd = rdata;
    req <= '0;
  endtask
  task automatic pulse(input logic sel_magic);
    @(posedge clock_i);
    if (sel_magic) magic <= 1'b1;
    else link <= 1'b1;
    @(posedge clock_i);
    magic <= 1'b0;
    link <= 1'b0;
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  initial begin
    repeat (260000) @(posedge clock_i);
    error_cnt++;
    test_done();
  end
  initial begin
    error_cnt = 0;
    checked = 0;
    arst_n_i = 1'b0;
    req = '0;
    {pin_a, pci_rst_n, pd_req, link, magic} = 5'h08;
    for (int i = 0; i < 64; i++) eeprom_model_i.mem[i] = 16'h5A00 + 16'(i);
    eeprom_model_i.mem[0] = 16'hA1B2;
    eeprom_model_i.mem[1] = 16'hC3D4;
    eeprom_model_i.mem[4] = {8'h01, ALC};
    eeprom_model_i.mem[5] = 16'h4E21;
    eeprom_model_i.mem[6] = 16'h7C35;
    eeprom_model_i.mem[7] = {CTL, PMB};
    eeprom_model_i.mem[10] = 16'h2211;
    eeprom_model_i.mem[11] = 16'h4433;
    eeprom_model_i.mem[12] = 16'h6655;
    repeat (5) @(posedge clock_i);
    check("reset fields", {pmr, mac[31:0]}, 64'h0);
    arst_n_i <= 1'b1;
    bus(1'b0, REG_STATUS, 32'h0);
    check("status early", rd[0], 1'b0);
    bus(1'b0, 6'h20, 32'h0);
    check("unmapped", rd, 32'h0);
    check("ids early", {vid, did}, {DEF_VID, DEF_DID});
    $display("test early done");
    for (int n = 0; n < 200000 && done !== 1'b1; n++) @(posedge clock_i);
    #1;
    check("words read", eeprom_model_i.words, 64'd13);
    check("command bits", eeprom_model_i.bad, 1'b0);
    check("pm register", pmr, {PMB[7:3], PMB[1:0], 3'h0, PMB[2], 21'h0});
    check("ids", {vid, did, svid, sid}, 64'h4E21_7C35_A1B2_C3D4);
    check("cap enable", new_capabilities_enable, 1'b1);
    check("station addr", mac, 48'h6655_4433_2211);
    bus(1'b0, REG_MAC_HI, 32'h0);
    check("control bytes", rd, {ALC, CTL, 16'h6655});
    $display("test load done");
    pulse(1'b1);
    repeat (4) @(posedge clock_i);
    #1;
    check("magic wake", wake, 1'b0);
    pulse(1'b0);
    repeat (3) @(posedge clock_i);
    #1;
    check("link wake", {wake, pme_oe, wol_oe, wake_output_pin}, 4'hE);
    repeat (20) @(posedge clock_i);
    #1;
    check("pulse end", wake, 1'b0);
    bus(1'b0, REG_STATUS, 32'h0);
    check("status kept", rd[4], 1'b1);
    bus(1'b1, REG_PM_CONTROL_STATUS, 32'h0000_8003);
    bus(1'b0, REG_PM_CONTROL_STATUS, 32'h0);
    check("state write", rd[15:0], 16'h0003);
    $display("test wake done");
    @(posedge clock_i);
    pci_rst_n <= 1'b0;
    pd_req <= 1'b1;
    repeat (5) @(posedge clock_i);
    #1;
    check("state cleared", pstate, 2'h0);
    check("phy kept", pd, 1'b0);
    @(posedge clock_i);
    pin_a <= 1'b1;
    repeat (5) @(posedge clock_i);
    #1;
    check("phy down", pd, 1'b1);
    $display("test pins done");
    test_done();
  end
endmodule
